// *** hdl/iec_pkg.sv ***
// Purpose: Shared constants for the interrupt entry and exit controller.
// Assumes: One 40 MHz clock, synchronous active-low reset.
// Notes: Register offsets are word aligned byte addresses on the Wishbone port.
package iec_pkg;
  localparam int IEC_NSRC = 8;
  localparam int IEC_PCW = 22;
  localparam int IEC_SPW = 16;
  localparam logic [IEC_SPW-1:0] IEC_SP_RESET = 16'h10FF;
  localparam logic [IEC_PCW-1:0] IEC_VEC_BASE = 22'h000002;
  localparam logic [IEC_PCW-1:0] IEC_VEC_STEP = 22'h000002;
  // Cycle figures of the entry and return sequences.
  localparam int IEC_ENTRY_CYC = 5;
  localparam int IEC_WAKE_EXTRA_CYC = 5;
  localparam int IEC_RETURN_CYC = 5;
  localparam int IEC_JUMP_CYC = 3;
  localparam int IEC_PC_BYTES = 3;
  // Register map.
  localparam logic [7:0] IEC_ADDR_FLAG = 8'h00;
  localparam logic [7:0] IEC_ADDR_ENABLE = 8'h04;
  localparam logic [7:0] IEC_ADDR_TYPE = 8'h08;
  localparam logic [7:0] IEC_ADDR_STATUS = 8'h0C;
  localparam logic [7:0] IEC_ADDR_SP = 8'h10;
  localparam logic [7:0] IEC_ADDR_PC = 8'h14;
  localparam int IEC_STATUS_GIE_BIT = 7;
  localparam logic [7:0] IEC_TYPE_RESET = 8'h00;
  typedef enum logic [2:0] {
    IEC_ST_RUN = 3'b000,
    IEC_ST_WAKE = 3'b001,
    IEC_ST_ENTRY = 3'b010,
    IEC_ST_JUMP = 3'b011,
    IEC_ST_RETURN = 3'b100,
    IEC_ST_HOLD = 3'b101
  } iec_state_t;
endpackage

// *** hdl/iec_prio.sv ***
// Purpose: Fixed priority picker, lowest index wins.
// Assumes: Combinational, same clock domain as the caller.
// Notes: Index zero is the external request zero source.
module iec_prio
  import iec_pkg::*;
#(
  parameter int N = IEC_NSRC
)
(
  input wire logic [N-1:0] req,
  output logic any,
  output logic [$clog2(N)-1:0] idx
);
  always_comb
  begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = i[$clog2(N)-1:0];
      end
    end
  end
endmodule

// *** hdl/iec_counter.sv ***
// Purpose: Down counter that times one sequence phase.
// Assumes: Load and count in the same clock domain.
// Notes: done is high in the last cycle of a loaded phase.
module iec_counter
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic load,
  input wire logic [3:0] loadVal,
  output logic done,
  output logic busy
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load)
      cnt_nxt = loadVal;
    else if (cnt_r != 4'h0)
      cnt_nxt = cnt_r - 4'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_nxt;
  end
  assign done = (cnt_r == 4'h1);
  assign busy = (cnt_r != 4'h0);
endmodule

// *** hdl/iec_ctrl.sv ***
// Purpose: Interrupt acceptance, entry and return sequencing of a small core.
// Assumes: Sequencer inputs are on clk_sys; source pins are asynchronous.
// Notes: Registers on classic Wishbone; stack bytes go out on a push/pop port.
//
// The Wishbone register port and the register offsets are this design's own decisions.
module iec_ctrl
  import iec_pkg::*;
#(
  parameter int NSRC = IEC_NSRC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [NSRC-1:0] srcPin,
  input wire logic instrBoundary,
  input wire logic instrSei,
  input wire logic instrCli,
  input wire logic instrReti,
  input wire logic sleeping,
  input wire logic [IEC_PCW-1:0] programCounter,
  input wire logic [7:0] stackRdData,
  output logic cpuHold,
  output logic pcLoad,
  output logic [IEC_PCW-1:0] pcLoadValue,
  output logic stackPush,
  output logic stackPop,
  output logic [IEC_SPW-1:0] stackAddr,
  output logic [7:0] stackWrData,
  output logic irqAck,
  output logic [$clog2(NSRC)-1:0] irqAckIdx,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int IW = $clog2(NSRC);
  localparam logic [3:0] ENTRY_LD = 4'(IEC_ENTRY_CYC);
  localparam logic [3:0] WAKE_LD = 4'(IEC_WAKE_EXTRA_CYC);
  localparam logic [3:0] RET_LD = 4'(IEC_RETURN_CYC);
  localparam logic [3:0] JUMP_LD = 4'(IEC_JUMP_CYC);

  logic [NSRC-1:0] sync1_r;
  logic [NSRC-1:0] sync2_r;
  logic [NSRC-1:0] prev_r;
  logic [NSRC-1:0] flag_r, flag_nxt;
  logic [NSRC-1:0] enable_r, enable_nxt;
  logic [NSRC-1:0] levelType_r, levelType_nxt;
  logic [7:0] status_r, status_nxt;
  logic [IEC_SPW-1:0] sp_r, sp_nxt;
  logic [IEC_PCW-1:0] savedPc_r, savedPc_nxt;
  logic [IEC_PCW-1:0] popPc_r, popPc_nxt;
  iec_state_t state_r, state_nxt;
  logic [IW-1:0] sel_r, sel_nxt;
  logic [1:0] byteCnt_r, byteCnt_nxt;
  logic blockOne_r, blockOne_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] eligible;
  logic anyEligible;
  logic [IW-1:0] winner;
  logic cntLoad;
  logic [3:0] cntLoadVal;
  logic cntDone;
  logic cntBusy;
  logic wbReq;
  logic wbWrite;
  logic gie;
  logic accept;
  logic [8*IEC_PC_BYTES-1:0] pcWide;

  // Source pins pass two flops; the first is read only by the second.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      sync1_r <= srcPin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign gie = status_r[IEC_STATUS_GIE_BIT];
  assign wbReq = wb_cyc_i && wb_stb_i && !ack_r;
  // A write lands at the edge that completes the cycle, while ack stands high.
  assign wbWrite = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
  // Zero-extended so the top pushed byte never reads past the counter's width.
  assign pcWide = (8*IEC_PC_BYTES)'(savedPc_r);

  // Level-type sources bypass the flag and request only while present.
  assign pending = (levelType_r & sync2_r) | (~levelType_r & flag_r);
  assign eligible = pending & enable_r & {NSRC{gie}};

  iec_prio #(
    .N(NSRC)
  ) u_prio (
    .req(eligible),
    .any(anyEligible),
    .idx(winner)
  );

  // A disable in this cycle, a fresh enable, or the first instruction after
  // a return all veto acceptance.
  assign accept = (state_r == IEC_ST_RUN) && instrBoundary && anyEligible
    && !instrCli && !instrSei && !instrReti && !blockOne_r;

  iec_counter u_cnt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(cntLoad),
    .loadVal(cntLoadVal),
    .done(cntDone),
    .busy(cntBusy)
  );

  always_comb
  begin
    flag_nxt = flag_r;
    enable_nxt = enable_r;
    levelType_nxt = levelType_r;
    status_nxt = status_r;
    sp_nxt = sp_r;
    savedPc_nxt = savedPc_r;
    popPc_nxt = popPc_r;
    state_nxt = state_r;
    sel_nxt = sel_r;
    byteCnt_nxt = byteCnt_r;
    blockOne_nxt = blockOne_r;
    cntLoad = 1'b0;
    cntLoadVal = 4'h0;
    ack_nxt = wbReq;
    rdData_nxt = rdData_r;
    cpuHold = (state_r != IEC_ST_RUN);
    pcLoad = 1'b0;
    pcLoadValue = '0;
    stackPush = 1'b0;
    stackPop = 1'b0;
    stackAddr = sp_r;
    stackWrData = 8'h00;
    irqAck = 1'b0;
    irqAckIdx = sel_r;
    // Software flag clear comes first so that a same-cycle edge wins.
    if (wbWrite && wb_adr_i == IEC_ADDR_FLAG)
      flag_nxt = flag_nxt & ~wb_dat_i[NSRC-1:0];
    if (accept && !levelType_r[winner])
      flag_nxt[winner] = 1'b0;
    // Edges latch regardless of either enable.
    flag_nxt = flag_nxt | (sync2_r & ~prev_r & ~levelType_r);
    if (wbWrite)
    begin
      case (wb_adr_i)
        IEC_ADDR_ENABLE: enable_nxt = wb_dat_i[NSRC-1:0];
        IEC_ADDR_TYPE: levelType_nxt = wb_dat_i[NSRC-1:0];
        // Software owns the whole status byte; setting GIE here nests.
        IEC_ADDR_STATUS: status_nxt = wb_dat_i[7:0];
        IEC_ADDR_SP: sp_nxt = wb_dat_i[IEC_SPW-1:0];
        default: ;
      endcase
    end
    if (instrCli)
      status_nxt[IEC_STATUS_GIE_BIT] = 1'b0;
    if (instrSei && state_r == IEC_ST_RUN)
      status_nxt[IEC_STATUS_GIE_BIT] = 1'b1;
    if (state_r == IEC_ST_RUN && instrBoundary)
      blockOne_nxt = 1'b0;
    case (state_r)
      IEC_ST_RUN:
      begin
        if (accept)
        begin
          status_nxt[IEC_STATUS_GIE_BIT] = 1'b0;
          sel_nxt = winner;
          savedPc_nxt = programCounter;
          byteCnt_nxt = 2'd0;
          irqAck = 1'b1;
          irqAckIdx = winner;
          cntLoad = 1'b1;
          if (sleeping)
          begin
            cntLoadVal = WAKE_LD;
            state_nxt = IEC_ST_WAKE;
          end
          else
          begin
            cntLoadVal = ENTRY_LD;
            state_nxt = IEC_ST_ENTRY;
          end
        end
        else if (instrReti && instrBoundary)
        begin
          byteCnt_nxt = 2'd0;
          cntLoad = 1'b1;
          cntLoadVal = RET_LD;
          state_nxt = IEC_ST_RETURN;
        end
      end
      IEC_ST_WAKE:
      begin
        if (cntDone)
        begin
          cntLoad = 1'b1;
          cntLoadVal = ENTRY_LD;
          state_nxt = IEC_ST_ENTRY;
        end
      end
      IEC_ST_ENTRY:
      begin
        // Low byte first, stack grows downward.
        if (byteCnt_r < 2'(IEC_PC_BYTES))
        begin
          stackPush = 1'b1;
          stackWrData = pcWide[8*byteCnt_r +: 8];
          sp_nxt = sp_r - 16'h0001;
          byteCnt_nxt = byteCnt_r + 2'd1;
        end
        if (cntDone)
        begin
          pcLoad = 1'b1;
          pcLoadValue = IEC_VEC_BASE + IEC_PCW'(sel_r) * IEC_VEC_STEP;
          cntLoad = 1'b1;
          cntLoadVal = JUMP_LD;
          state_nxt = IEC_ST_JUMP;
        end
      end
      IEC_ST_JUMP:
      begin
        if (cntDone)
          state_nxt = IEC_ST_RUN;
      end
      IEC_ST_RETURN:
      begin
        if (byteCnt_r < 2'(IEC_PC_BYTES))
        begin
          stackPop = 1'b1;
          stackAddr = sp_r + 16'h0001;
          sp_nxt = sp_r + 16'h0001;
          byteCnt_nxt = byteCnt_r + 2'd1;
        end
        if (byteCnt_r != 2'd0 && byteCnt_r <= 2'(IEC_PC_BYTES))
          popPc_nxt = {popPc_r[IEC_PCW-9:0], stackRdData};
        if (cntDone)
        begin
          pcLoad = 1'b1;
          pcLoadValue = popPc_r;
          status_nxt[IEC_STATUS_GIE_BIT] = 1'b1;
          blockOne_nxt = 1'b1;
          state_nxt = IEC_ST_RUN;
        end
      end
      default: state_nxt = IEC_ST_RUN;
    endcase
    if (wbReq && !wb_we_i)
    begin
      case (wb_adr_i)
        IEC_ADDR_FLAG: rdData_nxt = 32'(flag_r);
        IEC_ADDR_ENABLE: rdData_nxt = 32'(enable_r);
        IEC_ADDR_TYPE: rdData_nxt = 32'(levelType_r);
        IEC_ADDR_STATUS: rdData_nxt = {24'h000000, status_r};
        IEC_ADDR_SP: rdData_nxt = 32'(sp_r);
        IEC_ADDR_PC: rdData_nxt = {1'b0, cntBusy, 3'(state_r), 5'h00, savedPc_r};
        default: rdData_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      flag_r <= '0;
      enable_r <= '0;
      levelType_r <= NSRC'(IEC_TYPE_RESET);
      status_r <= 8'h00;
      sp_r <= IEC_SP_RESET;
      savedPc_r <= '0;
      popPc_r <= '0;
      state_r <= IEC_ST_RUN;
      sel_r <= '0;
      byteCnt_r <= 2'd0;
      blockOne_r <= 1'b0;
      ack_r <= 1'b0;
      rdData_r <= 32'h00000000;
    end
    else
    begin
      flag_r <= flag_nxt;
      enable_r <= enable_nxt;
      levelType_r <= levelType_nxt;
      status_r <= status_nxt;
      sp_r <= sp_nxt;
      savedPc_r <= savedPc_nxt;
      popPc_r <= popPc_nxt;
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      byteCnt_r <= byteCnt_nxt;
      blockOne_r <= blockOne_nxt;
      ack_r <= ack_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;
endmodule

// *** bench/iec_ctrl_assertions.sv ***
// Purpose: Port checker for the entry and return sequences.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Wake timing takes sleeping as seen in the acceptance cycle.
module iec_ctrl_assertions
  import iec_pkg::*;
#(
  parameter int NSRC = IEC_NSRC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instrBoundary,
  input wire logic instrSei,
  input wire logic instrCli,
  input wire logic instrReti,
  input wire logic sleeping,
  input wire logic cpuHold,
  input wire logic pcLoad,
  input wire logic [IEC_PCW-1:0] pcLoadValue,
  input wire logic stackPush,
  input wire logic stackPop,
  input wire logic irqAck,
  input wire logic [$clog2(NSRC)-1:0] irqAckIdx
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  entry_time_a: assert property (irqAck && !sleeping |-> ##5 pcLoad)
    else $error("vector load not five cycles after acceptance");
  vector_addr_a: assert property (irqAck && !sleeping |-> ##5
    pcLoadValue == IEC_VEC_BASE + IEC_VEC_STEP * $past(irqAckIdx, 5))
    else $error("wrong vector address");
  entry_push_a: assert property (irqAck && !sleeping |=> stackPush [*3] ##1 !stackPush)
    else $error("entry did not push three bytes");
  jump_hold_a: assert property (irqAck && !sleeping |-> ##6 cpuHold [*3] ##1 !cpuHold)
    else $error("jump hold not three cycles");
  wake_time_a: assert property (irqAck && sleeping |-> ##10 pcLoad)
    else $error("wake entry not five cycles longer");
  ret_pop_a: assert property (instrReti && instrBoundary && !cpuHold |=>
    stackPop [*3] ##1 !stackPop ##1 pcLoad)
    else $error("return did not pop three bytes in five cycles");
  ret_gap_a: assert property (pcLoad && $past(stackPop, 2) |=> !irqAck)
    else $error("entry straight after return");
  cli_block_a: assert property (instrCli |-> !irqAck)
    else $error("entry in disable cycle");
  sei_defer_a: assert property (instrSei |-> !irqAck)
    else $error("entry in enable cycle");
  boundary_only_a: assert property (irqAck |-> instrBoundary && !cpuHold)
    else $error("entry inside an instruction");
endmodule
bind iec_ctrl iec_ctrl_assertions #(.NSRC(NSRC)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .instrBoundary(instrBoundary), .instrSei(instrSei), .instrCli(instrCli),
  .instrReti(instrReti), .sleeping(sleeping), .cpuHold(cpuHold), .pcLoad(pcLoad),
  .pcLoadValue(pcLoadValue), .stackPush(stackPush), .stackPop(stackPop), .irqAck(irqAck),
  .irqAckIdx(irqAckIdx));

// *** bench/iec_seq_model.sv ***
// Purpose: Core sequencer and stack memory facing the controller.
// Assumes: Same clock as the controller.
// Notes: Instructions at addresses ending in 3 take two cycles.
module iec_seq_model
  import iec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cpuHold,
  input wire logic pcLoad,
  input wire logic [IEC_PCW-1:0] pcLoadValue,
  input wire logic stackPush,
  input wire logic stackPop,
  input wire logic [IEC_SPW-1:0] stackAddr,
  input wire logic [7:0] stackWrData,
  output logic instrBoundary,
  output logic [IEC_PCW-1:0] programCounter,
  output logic [7:0] stackRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic half_r;
  assign instrBoundary = !cpuHold && !(programCounter[1:0] == 2'h3 && !half_r);
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      programCounter <= 22'h000140;
      half_r <= 1'b0;
      stackRdData <= 8'h00;
    end
    else
    begin
      half_r <= !cpuHold && programCounter[1:0] == 2'h3 && !half_r;
      if (pcLoad)
        programCounter <= pcLoadValue;
      else if (instrBoundary)
        programCounter <= programCounter + 22'h000001;
      // Only return addresses reach this stack; status stays with software.
      if (stackPush)
        mem[stackAddr] <= stackWrData;
      // Outside a pop the lane is stale, so show its inverse rather than a plausible copy.
      stackRdData <= stackPop ? mem[stackAddr] : ~stackRdData;
    end
  end
endmodule

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the interrupt entry and exit controller.
// Assumes: Wishbone answers within 50 cycles; sequencer model drives the core side.
// Notes: Expected vectors and flags come from a small integer model.
module tb
  import iec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, nrst, sleeping, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instrBoundary, cpuHold;
  logic pcLoad, stackPush, stackPop, irqAck;
  logic [2:0] op, irqAckIdx, ixV;
  logic [7:0] srcPin, wb_adr_i, stackWrData, stackRdData;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rng, q;
  logic [IEC_PCW-1:0] programCounter, pcLoadValue, pcV;
  logic [IEC_SPW-1:0] stackAddr;
  int nFail, comparisons, pend, k;
  int ackCnt = 0, ldCnt = 0, ackUsed = 0, ldUsed = 0;
  logic [IEC_PCW-1:0] ackPc, ldVal, retOuter;
  logic [2:0] ackIdx;
  iec_ctrl u_dut (.clk_sys(clk_sys), .nrst(nrst), .srcPin(srcPin),
    .instrBoundary(instrBoundary), .instrSei(op[0]), .instrCli(op[1]), .instrReti(op[2]),
    .sleeping(sleeping), .programCounter(programCounter), .stackRdData(stackRdData),
    .cpuHold(cpuHold), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .stackPush(stackPush),
    .stackPop(stackPop), .stackAddr(stackAddr), .stackWrData(stackWrData), .irqAck(irqAck),
    .irqAckIdx(irqAckIdx), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  iec_seq_model u_seq (.clk_sys(clk_sys), .nrst(nrst), .cpuHold(cpuHold), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .stackPush(stackPush), .stackPop(stackPop),
    .stackAddr(stackAddr), .stackWrData(stackWrData), .instrBoundary(instrBoundary),
    .programCounter(programCounter), .stackRdData(stackRdData));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Records every entry and vector load, so no pulse is lost while a bus task is busy.
  always @(posedge clk_sys)
  begin
    if (irqAck === 1'b1)
    begin
      ackCnt <= ackCnt + 1;
      ackPc <= programCounter;
      ackIdx <= irqAckIdx;
    end
    if (pcLoad === 1'b1)
    begin
      ldCnt <= ldCnt + 1;
      ldVal <= pcLoadValue;
    end
  end
  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task finalReport;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, nFail);
    if (nFail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bail;
    nFail++;
    $display("Error wait expected answer seen none");
    finalReport();
  endtask
  task wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_sys);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (i == 50)
      bail();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string w);
    wbx(1'b0, a, 32'h0);
    chk(w, e, q);
  endtask
  task noAck(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      chk("irqAck", 32'h0, {31'h0, irqAck});
    end
  endtask
  task waitSig(input logic ld);
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk_sys);
      if (ld ? (ldCnt > ldUsed) : (ackCnt > ackUsed))
        break;
    end
    if (i == 100)
      bail();
    if (ld)
      ldUsed++;
    else
      ackUsed++;
    pcV = ld ? ldVal : ackPc;
    ixV = ackIdx;
  endtask
  // Held until a boundary is seen, as a multi-cycle instruction executes only at its end.
  task pulse(input logic [2:0] o);
    int i;
    op <= o;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (instrBoundary === 1'b1 && cpuHold === 1'b0)
        break;
    end
    if (i == 20)
      bail();
    op <= 3'h0;
  endtask
  task svc(input int idx, input logic flagChk);
    logic [IEC_PCW-1:0] ret;
    waitSig(1'b0);
    sleeping <= 1'b0;
    srcPin <= 8'h00;
    ret = pcV;
    chk("irqAckIdx", idx, {29'h0, ixV});
    waitSig(1'b1);
    chk("vector", IEC_VEC_BASE + IEC_VEC_STEP * idx, pcV);
    rd(IEC_ADDR_STATUS, 32'h0, "status");
    pend &= ~(1 << idx);
    if (flagChk)
      rd(IEC_ADDR_FLAG, pend, "flags");
    pulse(3'h4);
    waitSig(1'b1);
    chk("returnPc", ret, pcV);
  endtask
  initial
  begin
    nrst = 1'b0;
    srcPin = 8'h00;
    op = 3'h0;
    sleeping = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    nFail = 0;
    comparisons = 0;
    rng = 32'h0000001D;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(IEC_ADDR_SP, IEC_SP_RESET, "sp");
    rd(IEC_ADDR_STATUS, 32'h0, "status");
    rd(IEC_ADDR_TYPE, IEC_TYPE_RESET, "type");
    rd(8'h40, 32'h0, "unmapped");
    $display("Test reset done");
    rng = xs(rng);
    pend = rng[7:0] | 8'h22;
    srcPin <= pend[7:0];
    repeat (4) @(posedge clk_sys);
    srcPin <= 8'h00;
    repeat (4) @(posedge clk_sys);
    rd(IEC_ADDR_FLAG, pend, "flags");
    wbx(1'b1, IEC_ADDR_FLAG, 32'h0);
    rd(IEC_ADDR_FLAG, pend, "flags");
    wbx(1'b1, IEC_ADDR_FLAG, 32'h0000000F);
    pend &= 32'hF0;
    rd(IEC_ADDR_FLAG, pend, "flags");
    wbx(1'b1, IEC_ADDR_ENABLE, 32'h000000FF);
    noAck(8);
    wbx(1'b1, IEC_ADDR_STATUS, 32'h00000080);
    while (pend != 0)
    begin
      k = 0;
      while (!pend[k])
        k++;
      svc(k, 1'b1);
    end
    $display("Test priority done");
    wbx(1'b1, IEC_ADDR_TYPE, 32'h00000001);
    wbx(1'b1, IEC_ADDR_STATUS, 32'h0);
    srcPin <= 8'h01;
    repeat (4) @(posedge clk_sys);
    srcPin <= 8'h00;
    repeat (4) @(posedge clk_sys);
    wbx(1'b1, IEC_ADDR_STATUS, 32'h00000080);
    noAck(10);
    srcPin <= 8'h01;
    svc(0, 1'b0);
    $display("Test level done");
    pulse(3'h2);
    srcPin <= 8'h08;
    repeat (3) @(posedge clk_sys);
    srcPin <= 8'h00;
    noAck(10);
    rd(IEC_ADDR_STATUS, 32'h0, "status");
    pend = 8;
    sleeping <= 1'b1;
    pulse(3'h1);
    svc(3, 1'b1);
    $display("Test disable enable wake done");
    wbx(1'b1, IEC_ADDR_STATUS, 32'h0);
    pend = 32'hC0;
    srcPin <= 8'hC0;
    repeat (4) @(posedge clk_sys);
    srcPin <= 8'h00;
    repeat (4) @(posedge clk_sys);
    wbx(1'b1, IEC_ADDR_STATUS, 32'h00000080);
    waitSig(1'b0);
    retOuter = pcV;
    chk("irqAckIdx", 32'h6, {29'h0, ixV});
    pend &= 32'h80;
    waitSig(1'b1);
    wbx(1'b1, IEC_ADDR_STATUS, 32'h00000080);
    svc(7, 1'b1);
    pulse(3'h4);
    waitSig(1'b1);
    chk("returnPc", retOuter, pcV);
    $display("Test nesting done");
    finalReport();
  end
endmodule
